// ==== hw/ssp_pkg.sv ====
package ssp_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned BUS_CLK_NS  = 10;
    // Smallest legal divide of the bus clock for each role.
    localparam int unsigned MASTER_DIV  = 2;
    localparam int unsigned SLAVE_DIV   = 4;
    localparam int unsigned PIN_SCLK    = 0;
    localparam int unsigned PIN_MOSI    = 1;
    localparam int unsigned PIN_MISO    = 2;
    localparam int unsigned PIN_SS      = 3;
    localparam logic [3:0]  PIN_IDLE    = 4'h8;
    localparam logic [4:0]  LAST_EDGE   = 5'h0F;
    // The returning data bit reaches the master through the output flop and the pin synchroniser.
    localparam int unsigned MISO_LAT    = 5;
    localparam logic [4:0]  MASTER_DONE = 5'h14;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [7:0]  DATA_RESET  = 8'h00;
    localparam logic [7:0]  TX_FILL     = 8'h00;
    localparam logic [10:0] DIV_RESET   = 11'h000;
    localparam logic [1:0]  RST_RESET   = 2'h0;
    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_MASTER,
        SSP_SLAVE
    } ssp_state_e;
endpackage

// ==== hw/ssp_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ssp_fifo_if #(
    parameter int unsigned W = 8
);
    logic         push_valid;
    logic [W-1:0] push_data;
    logic         push_ready;
    logic         pop_valid;
    logic [W-1:0] pop_data;
    logic         pop_ready;
    logic         flush;
    logic         hold;
    modport fifo (input push_valid, push_data, pop_ready, flush, hold,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready, flush, hold,
                  input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ==== hw/ssp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
    parameter int unsigned W     = ssp_pkg::DATA_W,
    parameter int unsigned DEPTH = ssp_pkg::FIFO_DEPTH
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    ssp_fifo_if.fifo  port
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("ssp_fifo depth must be a power of two of at least two");
        end
    endgenerate

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    assign push = port.push_valid & port.push_ready;
    assign pop  = port.pop_valid & port.pop_ready;
    assign port.pop_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (port.flush) begin
            next_count = '0;
        end else if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Flags are registered so that both handshakes come straight from flops.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count          <= '0;
            wr_ptr         <= '0;
            rd_ptr         <= '0;
            port.push_ready <= 1'b0;
            port.pop_valid  <= 1'b0;
        end else begin
            count           <= next_count;
            port.push_ready <= (next_count != FULL_CNT) & !port.hold;
            port.pop_valid  <= (next_count != '0) & !port.hold;
            if (port.flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (push && !port.flush) begin
            mem[wr_ptr] <= port.push_data;
        end
    end

    no_overflow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        count <= FULL_CNT) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ==== hw/ssp_top.sv ====
//
// Summary of operation
// - Master bit rate at most bus/2, slave bus/4.
// - Master starts transfers; shift registers exchange bytes.
// - Written byte waits, loaded when transfer starts.
// - Completed byte moves into readable receive buffer.
// - Master drives clock, MOSI out, MISO in.
// - Slave takes clock pin, MISO out, MOSI in.
// - Prescaler divides bus clock by one to eight.
// - Rate divider adds power of two, 2-256.
// - Disabled port releases all four pins.
// - Master single-wire uses MOSI, direction by enable.
// - Slave single-wire uses MISO, direction by enable.
// - Unused data pin released in single-wire mode.
// - Master without fault enable releases select pin.
// - Select output enable picks fault input or output.
// - Port inactive in every stop mode.
// - Deep stop returns port to reset state.
// - Light stop halts clocks, keeps all state.
// - Interrupt exit resumes; reset exit resets.
// - Disable aborts, flushes, clears full, sets empty.
// - Polarity bit sets clock idle level.
// - Phase bit places first edge mid or start.
// - Order bit picks MSB or LSB first.
//
`timescale 1ns/1ps
`default_nettype none
module ssp_top #(
    parameter int unsigned FIFO_DEPTH = ssp_pkg::FIFO_DEPTH
) (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_enable,
    input  wire logic       i_master,
    input  wire logic       i_cpol,
    input  wire logic       i_cpha,
    input  wire logic       i_lsb_first,
    input  wire logic       i_single_wire,
    input  wire logic       i_bidir_oe,
    input  wire logic       i_mode_fault_en,
    input  wire logic       i_select_oe,
    input  wire logic [2:0] i_prescale,
    input  wire logic [2:0] i_rate,
    input  wire logic       i_stop_light,
    input  wire logic       i_stop_deep,
    input  wire logic       i_wr_valid,
    input  wire logic [7:0] i_wr_data,
    output logic            o_wr_ready,
    input  wire logic       i_rd_ack,
    output logic [7:0]      o_rx_data,
    output logic            o_receive_full,
    output logic            o_transmit_empty,
    input  wire logic       i_fault_clr,
    output logic            o_mode_fault,
    input  wire logic       i_sclk,
    output logic            o_sclk,
    output logic            o_sclk_oe,
    input  wire logic       i_mosi,
    output logic            o_mosi,
    output logic            o_mosi_oe,
    input  wire logic       i_miso,
    output logic            o_miso,
    output logic            o_miso_oe,
    input  wire logic       i_ss_n,
    output logic            o_ss_n,
    output logic            o_ss_oe
);
    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("ssp_top transmit depth must be a power of two of at least two");
        end
    endgenerate

    // Half a serial clock period in bus cycles: prescale times power of two.
    function automatic logic [10:0] half_period(input logic [2:0] pre, input logic [2:0] rate);
        return (11'({8'h00, pre}) + 11'h001) << rate;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= ssp_pkg::RST_RESET;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    logic clr;
    logic run;
    logic active;

    // Deep stop loses everything, so it acts like a reset of the engine.
    assign clr    = !i_enable | i_stop_deep;
    // Light stop freezes the engine flops in place instead of resetting them.
    assign run    = !i_stop_light;
    assign active = i_enable & !i_stop_light & !i_stop_deep;

    ////////////////////////////////////////////////////////////////////////
    // Pins are resynchronised; a level only counts once two stages agree.
    logic [3:0] pin_raw;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_f;

    assign pin_raw = {i_ss_n, i_miso, i_mosi, i_sclk};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                pin_s1[g] <= ssp_pkg::PIN_IDLE[g];
                pin_s2[g] <= ssp_pkg::PIN_IDLE[g];
                pin_s3[g] <= ssp_pkg::PIN_IDLE[g];
                pin_f[g]  <= ssp_pkg::PIN_IDLE[g];
            end else begin
                pin_s1[g] <= pin_raw[g];
                pin_s2[g] <= pin_s1[g];
                pin_s3[g] <= pin_s2[g];
                if (pin_s2[g] == pin_s3[g]) begin
                    pin_f[g] <= pin_s3[g];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ssp_fifo_if #(.W(ssp_pkg::DATA_W)) fif ();

    ssp_fifo #(
        .W     (ssp_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .port    (fif.fifo)
    );

    ssp_pkg::ssp_state_e state;
    logic [10:0] div_cnt;
    logic [4:0]  edge_cnt;
    logic [2:0]  bit_cnt;
    logic        msclk;
    logic        sclk_prev;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_word;
    logic [7:0]  load_data;
    logic        tick;
    logic [ssp_pkg::MISO_LAT-1:0] samp_pipe;
    logic        m_sample;
    logic        m_edge;
    logic        m_end;
    logic        s_edge;
    logic        s_lead;
    logic        selected;
    logic        mf_in;
    logic        start_m;
    logic        start_s;
    logic        load;
    logic        sample;
    logic        shift_ev;
    logic        byte_done;
    logic        din;
    logic        dout;

    assign fif.push_valid = i_wr_valid;
    assign fif.push_data  = i_wr_data;
    assign fif.pop_ready  = load & run;
    assign fif.flush      = clr;
    assign fif.hold       = i_stop_light;
    assign o_wr_ready     = fif.push_ready;

    assign tick     = (state == ssp_pkg::SSP_MASTER) && (edge_cnt <= ssp_pkg::LAST_EDGE) &&
                      (div_cnt == half_period(i_prescale, i_rate) - 11'h001);
    assign m_edge   = tick;
    // The select is held until the delayed last sample has landed.
    assign m_end    = (state == ssp_pkg::SSP_MASTER) && (edge_cnt == ssp_pkg::MASTER_DONE);
    assign m_sample = samp_pipe[ssp_pkg::MISO_LAT-1];
    assign selected = !pin_f[ssp_pkg::PIN_SS];
    // The slave sees the pin through the synchroniser, so bus/4 is its limit.
    assign s_edge   = (state == ssp_pkg::SSP_SLAVE) &&
                      (pin_f[ssp_pkg::PIN_SCLK] != sclk_prev);
    assign s_lead   = s_edge && (pin_f[ssp_pkg::PIN_SCLK] != i_cpol);
    assign mf_in    = active & i_master & i_mode_fault_en & !i_select_oe &
                      !pin_f[ssp_pkg::PIN_SS];
    assign start_m  = (state == ssp_pkg::SSP_IDLE) && active && i_master &&
                      fif.pop_valid && !mf_in;
    assign start_s  = (state == ssp_pkg::SSP_IDLE) && active && !i_master && selected;
    // Phase decides which edge samples; the other edge shifts the next bit.
    assign sample   = m_sample ||
                      (s_edge && (s_lead != i_cpha));
    assign shift_ev = (m_edge && (edge_cnt[0] != i_cpha) && (edge_cnt != 5'h00)) ||
                      (s_edge && (s_lead == i_cpha) && (bit_cnt != 3'h0));
    assign byte_done = sample && (bit_cnt == ssp_pkg::BIT_LAST);
    assign load     = start_m || start_s ||
                      ((state == ssp_pkg::SSP_SLAVE) && byte_done && selected);
    assign load_data = fif.pop_valid ? fif.pop_data : ssp_pkg::TX_FILL;
    assign dout     = i_lsb_first ? tx_sh[0] : tx_sh[7];
    assign din      = i_master ?
                      (i_single_wire ? pin_f[ssp_pkg::PIN_MOSI] : pin_f[ssp_pkg::PIN_MISO]) :
                      (i_single_wire ? pin_f[ssp_pkg::PIN_MISO] : pin_f[ssp_pkg::PIN_MOSI]);
    assign rx_word  = i_lsb_first ? {din, rx_sh[7:1]} : {rx_sh[6:0], din};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ssp_pkg::SSP_IDLE;
        end else if (clr) begin
            state <= ssp_pkg::SSP_IDLE;
        end else if (run) begin
            case (state)
                ssp_pkg::SSP_IDLE: begin
                    if (start_m) begin
                        state <= ssp_pkg::SSP_MASTER;
                    end else if (start_s) begin
                        state <= ssp_pkg::SSP_SLAVE;
                    end
                end
                ssp_pkg::SSP_MASTER: begin
                    if (mf_in || !i_master || m_end) begin
                        state <= ssp_pkg::SSP_IDLE;
                    end
                end
                ssp_pkg::SSP_SLAVE: begin
                    if (!selected || i_master) begin
                        state <= ssp_pkg::SSP_IDLE;
                    end
                end
                default: begin
                    state <= ssp_pkg::SSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= ssp_pkg::DIV_RESET;
            edge_cnt  <= 5'h00;
            bit_cnt   <= 3'h0;
            msclk     <= 1'b0;
            sclk_prev <= 1'b0;
            samp_pipe <= '0;
        end else if (clr) begin
            div_cnt   <= ssp_pkg::DIV_RESET;
            edge_cnt  <= 5'h00;
            bit_cnt   <= 3'h0;
            samp_pipe <= '0;
            msclk     <= i_cpol;
            sclk_prev <= pin_f[ssp_pkg::PIN_SCLK];
        end else if (run) begin
            sclk_prev <= pin_f[ssp_pkg::PIN_SCLK];
            if (state != ssp_pkg::SSP_MASTER) begin
                div_cnt   <= ssp_pkg::DIV_RESET;
                msclk     <= i_cpol;
                samp_pipe <= '0;
            end else begin
                samp_pipe <= {samp_pipe[ssp_pkg::MISO_LAT-2:0], m_edge && (edge_cnt[0] == i_cpha)};
                div_cnt <= tick ? ssp_pkg::DIV_RESET : div_cnt + 11'h001;
                if (m_edge) begin
                    msclk <= !msclk;
                end
            end
            if (state == ssp_pkg::SSP_IDLE) begin
                edge_cnt <= 5'h00;
                bit_cnt  <= 3'h0;
            end else begin
                if (m_edge || ((state == ssp_pkg::SSP_MASTER) && (edge_cnt > ssp_pkg::LAST_EDGE))) begin
                    edge_cnt <= edge_cnt + 5'h01;
                end
                if (sample) begin
                    bit_cnt <= bit_cnt + 3'h1;
                end
            end
        end
    end

    // Both shift registers run together, so a byte goes out as one comes in.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh <= ssp_pkg::DATA_RESET;
            rx_sh <= ssp_pkg::DATA_RESET;
        end else if (clr) begin
            tx_sh <= ssp_pkg::DATA_RESET;
            rx_sh <= ssp_pkg::DATA_RESET;
        end else if (run) begin
            if (load) begin
                tx_sh <= load_data;
            end else if (shift_ev) begin
                tx_sh <= i_lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
            end
            if (sample) begin
                rx_sh <= rx_word;
            end
        end
    end

    // A new byte sets the full flag even in the cycle software acknowledges.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rx_data        <= ssp_pkg::DATA_RESET;
            o_receive_full   <= 1'b0;
            o_transmit_empty <= 1'b1;
            o_mode_fault     <= 1'b0;
        end else if (clr) begin
            o_rx_data        <= ssp_pkg::DATA_RESET;
            o_receive_full   <= 1'b0;
            o_transmit_empty <= 1'b1;
            o_mode_fault     <= 1'b0;
        end else if (run) begin
            if (byte_done) begin
                o_rx_data <= rx_word;
            end
            o_receive_full   <= byte_done | (o_receive_full & !i_rd_ack);
            o_transmit_empty <= !fif.pop_valid;
            o_mode_fault     <= mf_in | (o_mode_fault & !i_fault_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic next_sclk_oe;
    logic next_mosi_oe;
    logic next_miso_oe;
    logic next_ss_oe;
    logic next_ss_n;

    always_comb begin
        next_sclk_oe = active & i_master;
        next_mosi_oe = active & i_master & (!i_single_wire | i_bidir_oe);
        next_miso_oe = active & !i_master & selected &
                       (!i_single_wire | i_bidir_oe);
        next_ss_oe   = active & i_master & i_mode_fault_en & i_select_oe;
        next_ss_n    = !(state == ssp_pkg::SSP_MASTER);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sclk    <= 1'b0;
            o_sclk_oe <= 1'b0;
            o_mosi    <= 1'b0;
            o_mosi_oe <= 1'b0;
            o_miso    <= 1'b0;
            o_miso_oe <= 1'b0;
            o_ss_n    <= 1'b1;
            o_ss_oe   <= 1'b0;
        end else begin
            o_sclk    <= msclk;
            o_sclk_oe <= next_sclk_oe;
            o_mosi    <= dout;
            o_mosi_oe <= next_mosi_oe;
            o_miso    <= dout;
            o_miso_oe <= next_miso_oe;
            o_ss_n    <= next_ss_n;
            o_ss_oe   <= next_ss_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    pins_released_a: assert property (!i_enable |=> !o_sclk_oe && !o_mosi_oe && !o_miso_oe && !o_ss_oe)
        else $error("pins driven while disabled");
    stop_released_a: assert property ((i_stop_light || i_stop_deep) |=> !o_sclk_oe && !o_mosi_oe)
        else $error("pins driven in stop");
    disable_flags_a: assert property (!i_enable |=> !o_receive_full ##1 o_transmit_empty)
        else $error("flags wrong after disable");
    master_clock_a: assert property (active && i_master |=> o_sclk_oe && o_sclk == $past(msclk))
        else $error("master clock not driven");
    slave_out_a: assert property (active && !i_master && !i_single_wire && selected |=> o_miso_oe && !o_mosi_oe)
        else $error("slave data out missing");
    master_bidir_a: assert property (active && i_master && i_single_wire |=> o_mosi_oe == $past(i_bidir_oe) && !o_miso_oe)
        else $error("master single wire direction wrong");
    slave_bidir_a: assert property (active && !i_master && i_single_wire |=> !o_mosi_oe)
        else $error("slave released pin driven");
    select_release_a: assert property (i_master && !i_mode_fault_en |=> !o_ss_oe)
        else $error("select pin not released");
    auto_select_a: assert property (state == ssp_pkg::SSP_MASTER |=> !o_ss_n)
        else $error("select not low in transfer");
    rx_capture_a: assert property (byte_done && !clr && run |=> o_receive_full && o_rx_data == $past(rx_word))
        else $error("received byte not captured");
    idle_level_a: assert property (state == ssp_pkg::SSP_IDLE && !clr && run ##1 state == ssp_pkg::SSP_IDLE |-> msclk == $past(i_cpol))
        else $error("clock idle level wrong");
    tx_load_a: assert property (start_m && run && !clr |=> tx_sh == $past(fif.pop_data))
        else $error("transmit byte not loaded");

    master_done_c: cover property (m_end && byte_done);
    slave_done_c: cover property (state == ssp_pkg::SSP_SLAVE && byte_done);
    fault_c: cover property (mf_in);
    bidir_c: cover property (i_single_wire && byte_done);
endmodule
`default_nettype wire

// ==== testbench/spp_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_slave_model (
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    input  wire logic       i_cpol,
    input  wire logic       i_cpha,
    input  wire logic       i_lsb_first,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] out = 8'h00;
    logic       skip;
    logic       cur;
    // The byte is loaded only while selected by the master.
    always @(negedge i_ss_n) begin
        out = i_tx;
        skip = i_cpha;
    end
    // With phase 1 the first leading edge presents the first bit, so it must not shift.
    always @(i_sclk) begin
        if (i_ss_n === 1'b0) begin
            if ((i_sclk !== i_cpol) === i_cpha) begin
                if (skip) skip = 1'b0;
                else out = i_lsb_first ? out >> 1 : out << 1;
            end else begin
                o_rx = i_lsb_first ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
            end
        end
    end
    assign cur = i_lsb_first ? out[0] : out[7];
    // Released line shows the inverse so a stale bit cannot pass for data.
    assign o_miso = i_ss_n ? ~cur : cur;
endmodule
`default_nettype wire

// ==== testbench/serial_peripheral_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_bench;
    typedef struct {logic [8:0] cfg; logic [7:0] tx; logic [7:0] stx;} spp_row_s;
    logic       clk, rst_n, en, mst, cpol, cpha, lsb, mfe, soe, wv, ack;
    logic [2:0] pre, rate;
    logic [7:0] wd, stx;
    wire logic  wr_rdy, rx_full, tx_empty, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, miso_m;
    wire logic  sclk_w, mosi_w, ss_w;
    wire logic [7:0] rx_d, srx;
    int         mismatches, compares, lowcnt;
    spp_row_s   rows [5] = '{'{9'h000, 8'hA5, 8'h3C}, '{9'h081, 8'h81, 8'h7E}, '{9'h148, 8'h01, 8'h80},
                             '{9'h1D1, 8'hC3, 8'h5A}, '{9'h07F, 8'h96, 8'hE1}};
    // Undriven pins settle at their pull-up or the idle clock level.
    assign sclk_w = sclk_oe ? sclk_o : cpol;
    assign mosi_w = mosi_oe ? mosi_o : 1'b1;
    assign ss_w   = ss_oe ? ss_o : 1'b1;
    ssp_top dut (.i_clk(clk), .i_arst_n(rst_n), .i_enable(en), .i_master(mst), .i_cpol(cpol), .i_cpha(cpha),
        .i_lsb_first(lsb), .i_single_wire(1'b0), .i_bidir_oe(1'b0), .i_mode_fault_en(mfe), .i_select_oe(soe),
        .i_prescale(pre), .i_rate(rate), .i_stop_light(1'b0), .i_stop_deep(1'b0), .i_wr_valid(wv),
        .i_wr_data(wd), .o_wr_ready(wr_rdy), .i_rd_ack(ack), .o_rx_data(rx_d), .o_receive_full(rx_full),
        .o_transmit_empty(tx_empty), .i_fault_clr(1'b0), .o_mode_fault(), .i_sclk(sclk_w), .o_sclk(sclk_o),
        .o_sclk_oe(sclk_oe), .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(miso_m),
        .o_miso(miso_o), .o_miso_oe(miso_oe), .i_ss_n(ss_w), .o_ss_n(ss_o), .o_ss_oe(ss_oe));
    spp_slave_model partner (.i_sclk(sclk_w), .i_mosi(mosi_w), .i_ss_n(ss_w), .i_cpol(cpol), .i_cpha(cpha),
        .i_lsb_first(lsb), .i_tx(stx), .o_miso(miso_m), .o_rx(srx));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (ss_w === 1'b0) lowcnt++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        wv = 1'b1;
        wd = d;
        while (wr_rdy !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        wv = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_for(input int lim);
        int n;
        n = 0;
        while (!(tx_empty === 1'b1 && ss_w === 1'b1 && rx_full === 1'b1) && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        {rst_n, en, mst, cpol, cpha, lsb, mfe, soe, wv, ack, pre, rate, wd, stx} = '0;
        {en, mst, mfe, soe} = 4'hF;
        repeat (2) @(negedge clk);
        chk({sclk_oe, mosi_oe, miso_oe, ss_oe, ss_o, wr_rdy, tx_empty, rx_full}, 8'h0A);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            {cpol, cpha, lsb, pre, rate} = rows[i].cfg;
            stx = rows[i].stx;
            repeat (3) @(negedge clk);
            lowcnt = 0;
            put(rows[i].tx);
            wait_for(20000);
            chk(rx_d, rows[i].stx);
            chk(srx, rows[i].tx);
            chk(16'(lowcnt), 16'(16 * ((pre + 1) << rate) + ssp_pkg::MISO_LAT));
            chk({sclk_o, sclk_oe, mosi_oe, miso_oe, ss_oe}, {cpol, 4'hD});
            ack = 1'b1;
            @(negedge clk);
            ack = 1'b0;
            chk(rx_full, 1'b0);
        end
        // An unselected slave never starts, which lets the queue fill to refusal.
        {mst, pre, rate} = 7'h00;
        for (int i = 0; i < 8; i++) put(8'h10 + 8'(i));
        @(negedge clk);
        chk({wr_rdy, tx_empty}, 2'b00);
        mst = 1'b1;
        wait_for(3000);
        chk(srx, 8'h17);
        put(8'h55);
        while (ss_w !== 1'b0 && compares < 1000) @(negedge clk);
        en = 1'b0;
        repeat (4) @(negedge clk);
        chk({sclk_oe, mosi_oe, miso_oe, ss_oe}, 4'h0);
        chk({rx_full, tx_empty}, 2'b01);
        report_and_stop();
    end
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
